// ### rtl/drac_pkg.sv
package drac_pkg;

  // strap combination {wait_state, rate1, rate0}
  typedef struct packed {
    logic wait_state_strap;
    logic rate_select_strap1;
    logic rate_select_strap0;
  } drac_straps_t;

  // latched access request
  typedef struct packed {
    logic [7:0] row;
    logic [7:0] col;
    logic       cs_n;
    logic       bank;
  } drac_req_t;

  localparam int RATE_W        = 7;
  localparam int RATE_DIV_31   = 31;
  localparam int RATE_DIV_46   = 46;
  localparam int RATE_DIV_61   = 61;
  localparam int RATE_DIV_76   = 76;
  localparam int RATE_DIV_91   = 91;
  localparam int REF_CLKS_SHORT = 3;
  localparam int REF_CLKS_LONG  = 4;
  localparam logic [7:0] REF_ADDR_RST = 8'hff;

  // column address settle time before column strobe
  localparam int CLK_PERIOD_NS   = 25;
  localparam int COL_SETTLE_NS   = 25;
  localparam int COL_SETTLE_CLKS =
    (COL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ROW    = 3'b001,
    ST_COL    = 3'b010,
    ST_REF    = 3'b011,
    ST_PRECH  = 3'b100
  } drac_state_t;

endpackage : drac_pkg

// ### rtl/drac_rate_gen.sv
`timescale 1ns/1ps
// refresh rate divider; flags a due refresh for one cycle
module drac_rate_gen #(
  parameter int W = 7
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic [W-1:0] ratio,
  output logic              due_ff
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  wire          hit = (ratio != '0) && (cnt_ff == ratio - W'(1));

  assign nxt_cnt = (clr || hit) ? '0 : cnt_ff + W'(1);

  // counts on the rising edge only, so the flag is edge aligned
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= '0;
      due_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      due_ff <= hit && !clr;
    end
  end
endmodule : drac_rate_gen

// ### rtl/drac_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// R1: strobe high and no refresh: row inputs pass straight to address outputs
// R2: rate divider divides clock by 31/46/61/76/91 per straps
// R3: rate counter cleared on refresh request and while all straps low
// R4: system drives all straps low at power-up to initialise counters
// R5: eight-bit refresh row counter decremented after every refresh
// R6: address mux picks row, column or refresh value by cycle phase
// R7: arbiter runs access or refresh, defers the loser until done
// R8: refresh clears rate divider, decrements counter; control steers mux
// R9: strobe falling edge captures row, column, chip and bank select
// R10: selected access drives row and asserts the chosen bank row strobe
// R11: master drops column strobe after latch strobe to request column
// R12: column strobe waits until column address has settled
// R13: wait-state strap high pulls ready low every memory cycle
// R14: access during refresh: ready low, finish refresh, then row strobe
// R15: deferred access raises ready when its cycle begins
// R16: refresh due between back-to-back accesses runs between them
// R17: internal refresh request raised only on rising clock edge
// R18: access or refresh decided on following falling clock edge
// R19: grant cycle with wait strap raises ready after mux switch
// R20: grant cycle ends like normal access when master releases strobes
// R21: all straps low: refresh only on external request
// R22: late column strobe times column strobe from clock edge
// R23: grant cycle has exactly one clock of row strobe precharge
// R24: refresh lasts three or four clocks per strap setting
// R25: refresh drives counter on address and row strobes, no column strobe
module drac_ctrl #(
  parameter int RATE_W = drac_pkg::RATE_W
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire drac_pkg::drac_straps_t straps,
  input  wire logic                 addr_latch_strobe,
  input  wire logic                 chip_select_n,
  input  wire logic                 bank_select_in,
  input  wire logic                 column_access_strobe_in,
  input  wire logic [7:0]           row_addr_in,
  input  wire logic [7:0]           col_addr_in,
  input  wire logic                 ext_refresh_request_n,
  output logic [7:0]                mem_addr_out,
  output logic                      row_strobe_bank0,
  output logic                      row_strobe_bank1,
  output logic                      col_strobe_n,
  output logic                      ready
);
  // the largest divisor must fit the rate counter
  if (RATE_W < 7)
  begin : g_rate_w_check
    $error("rate counter too narrow for divide by 91");
  end

  drac_pkg::drac_state_t state_ff, nxt_state;
  drac_pkg::drac_req_t   req_ff;
  logic [7:0]  ref_addr_ff;
  logic [2:0]  phase_ff;
  logic        ale_d_ff;
  logic        pend_ff;
  logic        grant_ff;
  logic        ref_due_ff;
  logic        decide_neg_ff;
  logic        ready_ff;
  logic [7:0]  addr_ff;
  logic        row_strobe_bank0_ff, row_strobe_bank1_ff, cas_ff;
  logic        ext_d_ff;

  // strap decode
  wire logic [2:0] strap_code = straps;
  wire logic straps_low = (strap_code == 3'b000);
  wire logic wait_on    = straps.wait_state_strap;
  logic [RATE_W-1:0] ratio;
  logic [2:0]        ref_len;

  // R2 ratio select
  always_comb
  begin
    unique case (strap_code)
      3'b000: ratio = '0;
      3'b001: ratio = RATE_W'(drac_pkg::RATE_DIV_31);
      3'b010: ratio = RATE_W'(drac_pkg::RATE_DIV_46);
      3'b011: ratio = RATE_W'(drac_pkg::RATE_DIV_61);
      3'b100: ratio = RATE_W'(drac_pkg::RATE_DIV_46);
      3'b101: ratio = RATE_W'(drac_pkg::RATE_DIV_61);
      3'b110: ratio = RATE_W'(drac_pkg::RATE_DIV_76);
      3'b111: ratio = RATE_W'(drac_pkg::RATE_DIV_91);
    endcase
  end

  // R24 refresh length per strap
  assign ref_len = (strap_code == 3'b001 || strap_code == 3'b010 ||
                    strap_code == 3'b100)
                   ? 3'(drac_pkg::REF_CLKS_SHORT)
                   : 3'(drac_pkg::REF_CLKS_LONG);

  // R9 latch strobe falling edge sampled on the clock
  wire logic ale_fall = ale_d_ff && !addr_latch_strobe;
  wire logic new_acc  = ale_fall && !chip_select_n;
  wire logic ext_req  = ext_d_ff && !ext_refresh_request_n;
  wire logic rate_due;
  wire logic start_ref = (state_ff == drac_pkg::ST_REF) &&
                         (phase_ff == 3'd0);

  // R3 clear on the first clock of a refresh or while straps low
  drac_rate_gen #(
    .W      (RATE_W)
  ) u_rate (
    .ref_clk(ref_clk),
    .rst    (rst),
    .clr    (start_ref || straps_low),
    .ratio  (ratio),
    .due_ff (rate_due)
  );

  // R18 arbitration decision on the falling edge after a request
  always_ff @(negedge ref_clk or posedge rst)
  begin
    if (rst)
      decide_neg_ff <= 1'b0;
    else
      decide_neg_ff <= ref_due_ff;
  end

  wire logic ref_take = decide_neg_ff && (state_ff == drac_pkg::ST_IDLE);
  wire logic acc_go   = (pend_ff || new_acc) && !ref_take;
  wire logic col_req  = !column_access_strobe_in;
  wire logic ref_done = (state_ff == drac_pkg::ST_REF) &&
                        (phase_ff == ref_len - 3'd1);
  wire logic acc_end  = (state_ff == drac_pkg::ST_COL ||
                         state_ff == drac_pkg::ST_ROW) &&
                        addr_latch_strobe && column_access_strobe_in;

  // R7 cycle sequencing
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      drac_pkg::ST_IDLE:
        if (ref_take)
          nxt_state = drac_pkg::ST_REF;
        else if (acc_go)
          nxt_state = drac_pkg::ST_ROW;
      drac_pkg::ST_ROW:
        if (acc_end)
          nxt_state = drac_pkg::ST_IDLE;
        else if (col_req)
          nxt_state = drac_pkg::ST_COL;
      // R20 master release ends the access
      drac_pkg::ST_COL:
        if (acc_end)
          nxt_state = drac_pkg::ST_IDLE;
      drac_pkg::ST_REF:
        if (ref_done)
          nxt_state = (pend_ff || new_acc) ? drac_pkg::ST_PRECH
                                           : drac_pkg::ST_IDLE;
      // R23 one clock of precharge then row strobe
      drac_pkg::ST_PRECH:
        nxt_state = drac_pkg::ST_ROW;
      default:
        nxt_state = drac_pkg::ST_IDLE;
    endcase
  end

  // R17 refresh request held from rising edge until taken
  // R21 external request is the only source when straps are low
  wire logic nxt_due = (rate_due || ext_req) ? 1'b1 :
                       (start_ref ? 1'b0 : ref_due_ff);

  // request capture and bookkeeping
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff   <= drac_pkg::ST_IDLE;
      req_ff     <= '0;
      ale_d_ff   <= 1'b0;
      ext_d_ff   <= 1'b1;
      pend_ff    <= 1'b0;
      grant_ff   <= 1'b0;
      ref_due_ff <= 1'b0;
      phase_ff   <= 3'd0;
    end
    else
    begin
      state_ff   <= nxt_state;
      ale_d_ff   <= addr_latch_strobe;
      ext_d_ff   <= ext_refresh_request_n;
      ref_due_ff <= nxt_due;
      phase_ff   <= (nxt_state == state_ff) ? phase_ff + 3'd1 : 3'd0;
      // R9 capture on strobe fall
      if (ale_fall)
        req_ff <= {row_addr_in, col_addr_in, chip_select_n,
                   bank_select_in};
      // R14 R16 access held off waits here
      if (new_acc && (ref_take || state_ff != drac_pkg::ST_IDLE))
        pend_ff <= 1'b1;
      else if (nxt_state == drac_pkg::ST_ROW)
        pend_ff <= 1'b0;
      if (state_ff == drac_pkg::ST_PRECH)
        grant_ff <= 1'b1;
      else if (nxt_state == drac_pkg::ST_IDLE)
        grant_ff <= 1'b0;
    end
  end

  // R5 R8 refresh row counter steps down after each refresh
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ref_addr_ff <= drac_pkg::REF_ADDR_RST;
    else if (ref_done)
      ref_addr_ff <= ref_addr_ff - 8'h01;
  end

  // R1 R6 address mux, transparent while latch strobe is high
  wire logic in_ref = (state_ff == drac_pkg::ST_REF);
  // R12 column address goes out one clock ahead of the column strobe
  wire logic col_sel = (state_ff == drac_pkg::ST_COL) ||
                       (nxt_state == drac_pkg::ST_COL && !addr_latch_strobe);
  // the capturing edge still finds the row on the inputs, not in req_ff
  wire logic row_pass = (addr_latch_strobe || ale_fall) && !pend_ff;
  wire logic [7:0] nxt_addr =
    in_ref   ? ref_addr_ff :
    col_sel  ? req_ff.col :
    row_pass ? row_addr_in :
    req_ff.row;

  // R12 column strobe only after address has had a clock to settle
  // R22 also covers the late column request: timed by the clock
  wire logic col_settled = (state_ff == drac_pkg::ST_COL) &&
    (phase_ff >= 3'(drac_pkg::COL_SETTLE_CLKS - 1));

  // R10 R25 row strobe per bank, both banks on refresh
  wire logic row_act = (nxt_state == drac_pkg::ST_ROW) ||
                       (state_ff == drac_pkg::ST_COL && !acc_end) ||
                       (state_ff == drac_pkg::ST_ROW && !acc_end);
  wire logic bank1 = (state_ff == drac_pkg::ST_IDLE && new_acc)
                     ? bank_select_in : req_ff.bank;
  wire logic nxt_row_strobe_bank0 = !((in_ref && !ref_done) || (row_act && !bank1));
  wire logic nxt_row_strobe_bank1 = !((in_ref && !ref_done) || (row_act && bank1));

  // R13 R14 R15 R16 R19 ready timing
  wire logic held   = new_acc &&
                      (ref_take || state_ff != drac_pkg::ST_IDLE);
  wire logic wait_n = wait_on && new_acc && !held;
  wire logic nxt_ready =
    (held || wait_n)                         ? 1'b0 :
    (pend_ff && nxt_state == drac_pkg::ST_ROW && !wait_on) ? 1'b1 :
    (state_ff == drac_pkg::ST_COL && (grant_ff || wait_on)) ? 1'b1 :
    (state_ff == drac_pkg::ST_IDLE && !pend_ff) ? 1'b1 :
    ready_ff;

  // outputs registered
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_ff  <= 8'h00;
      row_strobe_bank0_ff  <= 1'b1;
      row_strobe_bank1_ff  <= 1'b1;
      cas_ff   <= 1'b1;
      ready_ff <= 1'b1;
    end
    else
    begin
      addr_ff  <= nxt_addr;
      row_strobe_bank0_ff  <= nxt_row_strobe_bank0;
      row_strobe_bank1_ff  <= nxt_row_strobe_bank1;
      cas_ff   <= !(col_settled && !acc_end);
      ready_ff <= nxt_ready;
    end
  end

  assign mem_addr_out     = addr_ff;
  assign row_strobe_bank0 = row_strobe_bank0_ff;
  assign row_strobe_bank1 = row_strobe_bank1_ff;
  assign col_strobe_n     = cas_ff;
  assign ready            = ready_ff;

  // R5 counter moves by exactly one per refresh
  property p_ref_dec;
    @(posedge ref_clk) disable iff (rst)
      ref_done |=> ref_addr_ff == $past(ref_addr_ff) - 8'h01;
  endproperty
  a_ref_dec: assert property (p_ref_dec) // R5
    else $error("refresh counter did not step down");

  // R25 no column strobe during refresh
  property p_ref_nocas;
    @(posedge ref_clk) disable iff (rst)
      in_ref |=> col_strobe_n;
  endproperty
  a_ref_nocas: assert property (p_ref_nocas) // R25
    else $error("column strobe during refresh");

  // R24 refresh length bounded by four clocks
  property p_ref_len;
    @(posedge ref_clk) disable iff (rst)
      $rose(in_ref) |-> ##[3:4] !in_ref;
  endproperty
  a_ref_len: assert property (p_ref_len) // R24
    else $error("refresh length wrong");

  // R23 precharge lasts one clock
  property p_prech;
    @(posedge ref_clk) disable iff (rst)
      state_ff == drac_pkg::ST_PRECH |=> state_ff == drac_pkg::ST_ROW;
  endproperty
  a_prech: assert property (p_prech) // R23
    else $error("precharge not one clock");

  // R14 held access drops ready
  property p_held_rdy;
    @(posedge ref_clk) disable iff (rst)
      held |=> !ready;
  endproperty
  a_held_rdy: assert property (p_held_rdy) // R14
    else $error("ready not low on held access");

  // R1 transparent row path
  property p_transp;
    @(posedge ref_clk) disable iff (rst)
      addr_latch_strobe && !in_ref && !pend_ff &&
      state_ff != drac_pkg::ST_COL |=> mem_addr_out == $past(row_addr_in);
  endproperty
  a_transp: assert property (p_transp) // R1
    else $error("row address not passed through");

  // R21 straps low keep rate divider quiet
  property p_ext_only;
    @(posedge ref_clk) disable iff (rst)
      straps_low [*2] |-> !rate_due;
  endproperty
  a_ext_only: assert property (p_ext_only) // R21
    else $error("internal refresh with straps low");

  // R10 access picks captured bank
  property p_bank;
    @(posedge ref_clk) disable iff (rst)
      state_ff == drac_pkg::ST_COL && !acc_end |=>
        (req_ff.bank ? !row_strobe_bank1 : !row_strobe_bank0);
  endproperty
  a_bank: assert property (p_bank) // R10
    else $error("wrong bank row strobe");

  // R10 row strobe goes out together with the captured row address
  property p_row_addr;
    @(posedge ref_clk) disable iff (rst)
      state_ff == drac_pkg::ST_ROW |-> mem_addr_out == req_ff.row;
  endproperty
  a_row_addr: assert property (p_row_addr) // R10
    else $error("row address not on outputs during row phase");

  // R12 column strobe falls only onto an address that already stood
  property p_col_settle;
    @(posedge ref_clk) disable iff (rst)
      $fell(col_strobe_n) |->
        mem_addr_out == req_ff.col && $past(mem_addr_out) == req_ff.col;
  endproperty
  a_col_settle: assert property (p_col_settle) // R12
    else $error("column strobe before column address settled");

endmodule : drac_ctrl

// ### test/drac_master.sv
`timescale 1ns/1ps
// bus master: one access at a time, held until released
module drac_master (
  input  wire logic       ref_clk,
  input  wire logic [7:0] mem_addr_out,
  input  wire logic       row_strobe_bank0,
  input  wire logic       row_strobe_bank1,
  input  wire logic       col_strobe_n,
  input  wire logic       ready,
  output logic            ale,
  output logic            cs_n,
  output logic            bank,
  output logic            cas_in_n,
  output logic [7:0]      row,
  output logic [7:0]      col
);
  // idle bus: no strobe, chip not selected
  initial
  begin
    ale = 1'b0;
    cs_n = 1'b1;
    bank = 1'b0;
    cas_in_n = 1'b1;
    row = 8'h00;
    col = 8'h00;
  end

  // o = {pass-through, row, col} addresses; fl = {ready_low, ready_at_row, done}
  task automatic access(
    input  logic [7:0]  r,
    input  logic [7:0]  c,
    input  logic        b,
    input  logic        sel_n,
    output logic [23:0] o,
    output logic [1:0]  ras,
    output logic [2:0]  fl,
    output int          ncas
  );
    int n;
    fl = 3'b000;
    o = 24'h000000;
    @(posedge ref_clk);
    #2;
    ale = 1'b1;
    row = r;
    col = c;
    cs_n = sel_n;
    bank = b;
    @(posedge ref_clk);
    #2;
    o[23:16] = mem_addr_out;
    ale = 1'b0;
    @(posedge ref_clk);
    #2;
    // stale lines show the inverse so a late capture cannot pass
    row = ~r;
    col = ~c;
    cs_n = ~sel_n;
    bank = ~b;
    fl[2] = ~ready;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #2;
      ras = {row_strobe_bank1, row_strobe_bank0};
      fl[2] = fl[2] | ~ready;
      n++;
    end
    while (!sel_n && ras != 2'b01 && ras != 2'b10 && n < 16);
    o[15:8] = mem_addr_out;
    fl[1] = ready;
    ncas = (n < 16) ? 0 : 99;
    if (!sel_n && n < 16)
    begin
      cas_in_n = 1'b0;
      do
      begin
        @(posedge ref_clk);
        #2;
        fl[2] = fl[2] | ~ready;
        ncas++;
      end
      while (col_strobe_n && ncas < 8);
      o[7:0] = mem_addr_out;
      ale = 1'b1;
      cas_in_n = 1'b1;
      repeat (2) @(posedge ref_clk);
      #2;
      fl[0] = row_strobe_bank0 & row_strobe_bank1 & col_strobe_n & ready;
    end
  endtask : access
endmodule : drac_master

// ### test/tb.sv
`timescale 1ns/1ps
// random accesses, refresh timing and arbitration
module tb;
  logic                   ref_clk;
  logic                   rst;
  logic                   ext_n;
  drac_pkg::drac_straps_t straps;
  logic                   ale, cs_n, bank, cas_in_n, rs0, rs1, cas_n, rdy;
  logic [7:0]             row, col, maddr, ref_exp, r, c;
  logic                   b, w, sn;
  logic [23:0]            o;
  logic [1:0]             ras;
  logic [2:0]             fl;
  int                     bad_count, check_count, ncas, dly, len, i;

  drac_ctrl dut_u (
    .ref_clk                 (ref_clk),
    .rst                     (rst),
    .straps                  (straps),
    .addr_latch_strobe       (ale),
    .chip_select_n           (cs_n),
    .bank_select_in          (bank),
    .column_access_strobe_in (cas_in_n),
    .row_addr_in             (row),
    .col_addr_in             (col),
    .ext_refresh_request_n   (ext_n),
    .mem_addr_out            (maddr),
    .row_strobe_bank0        (rs0),
    .row_strobe_bank1        (rs1),
    .col_strobe_n            (cas_n),
    .ready                   (rdy)
  );

  drac_master bus_u (
    .ref_clk          (ref_clk),
    .mem_addr_out     (maddr),
    .row_strobe_bank0 (rs0),
    .row_strobe_bank1 (rs1),
    .col_strobe_n     (cas_n),
    .ready            (rdy),
    .ale              (ale),
    .cs_n             (cs_n),
    .bank             (bank),
    .cas_in_n         (cas_in_n),
    .row              (row),
    .col              (col)
  );

  // expected divisor and refresh length per strap code
  function automatic int div_of(input logic [2:0] k);
    case (k)
      3'b001: return drac_pkg::RATE_DIV_31;
      3'b010, 3'b100: return drac_pkg::RATE_DIV_46;
      3'b011, 3'b101: return drac_pkg::RATE_DIV_61;
      3'b110: return drac_pkg::RATE_DIV_76;
      default: return drac_pkg::RATE_DIV_91;
    endcase
  endfunction : div_of

  function automatic int len_of(input logic [2:0] k);
    return (k == 3'b001 || k == 3'b010 || k == 3'b100) ?
           drac_pkg::REF_CLKS_SHORT : drac_pkg::REF_CLKS_LONG;
  endfunction : len_of

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // waits for a refresh (bounded), checks address, measures length
  task automatic watch_ref(output int d, output int n);
    d = 0;
    n = 0;
    while ({rs1, rs0} != 2'b00 && d < 200)
    begin
      @(posedge ref_clk);
      #2;
      d++;
    end
    ext_n = 1'b1;
    if (d >= 200)
    begin
      bad_count++;
      finish_test();
    end
    // counter on address, no column strobe
    check({maddr, 7'h00, cas_n}, {ref_exp, 8'h01});
    while ({rs1, rs0} == 2'b00 && n < 8)
    begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    // the first clock of a refresh is its row strobe precharge
    n++;
    // counter steps down after each refresh
    ref_exp = ref_exp - 8'h01;
  endtask : watch_ref

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // main sequence
  initial
  begin
    straps = 3'b000;
    rst = 1'b1;
    ext_n = 1'b1;
    bad_count = 0;
    check_count = 0;
    ref_exp = drac_pkg::REF_ADDR_RST;
    i = $urandom(32'hd3d18f50);
    repeat (12) @(posedge ref_clk);
    #2;
    check({maddr, 4'h0, rs1, rs0, cas_n, rdy}, 16'h000f);
    rst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #2;
    // random accesses, wait strap set just before each so no refresh is due
    for (i = 0; i < 14; i++)
    begin
      r = 8'($urandom);
      c = (i == 0) ? 8'hff : 8'($urandom);
      b = 1'($urandom);
      w = 1'($urandom);
      sn = (i % 5 == 4);
      straps = {w, 2'b00};
      bus_u.access(r, c, b, sn, o, ras, fl, ncas);
      straps = 3'b000;
      // one edge with all straps low clears the divider between accesses
      @(posedge ref_clk);
      #2;
      if (ncas > 50)
      begin
        bad_count++;
        finish_test();
      end
      check(o[23:16], r);
      check(ras, sn ? 2'b11 : {~b, b});
      if (!sn)
      begin
        check(o[15:8], r);
        check(o[7:0], c);
        check({fl[2], fl[1]}, {w, ~w});
        check(ncas >= 2 && ncas <= 3, 1'b1);
        check(fl[0], 1'b1);
      end
    end
    // external requests only, four clocks each
    for (i = 0; i < 3; i++)
    begin
      ext_n = 1'b0;
      watch_ref(dly, len);
      check(16'(len), 16'(drac_pkg::REF_CLKS_LONG));
    end
    // every nonzero strap code: divisor and refresh length
    for (i = 1; i < 8; i++)
    begin
      straps = 3'(i);
      watch_ref(dly, len);
      straps = 3'b000;
      // clear the divider so the next code counts from zero
      @(posedge ref_clk);
      #2;
      check(dly >= div_of(3'(i)) && dly <= div_of(3'(i)) + 4, 1'b1);
      check(16'(len), 16'(len_of(3'(i))));
    end
    // all straps low: divider held clear, no refresh of its own
    dly = 0;
    for (i = 0; i < 150; i++)
    begin
      @(posedge ref_clk);
      #2;
      dly += ({rs1, rs0} == 2'b00);
    end
    check(16'(dly), 16'h0000);
    // access arriving mid-refresh is held, then granted
    ext_n = 1'b0;
    fork
      watch_ref(dly, len);
      bus_u.access(8'h5a, 8'ha5, 1'b1, 1'b0, o, ras, fl, ncas);
    join
    check(o[15:8], 8'h5a);
    check(fl, 3'b111);
    finish_test();
  end
endmodule : tb
